// ### io_port_input_instructions_tb.sv
module io_port_input_instructions_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00, o, im;
   logic [31:0] pwdata_i = 32'h0, prdata_o, io_rdata_i, rd, m;
   logic        pready_o, pslverr_o, irq_o, perm_deny_i, io_req_o, io_ack_i, mem_req_o, mem_ack_i, mem_page_miss_i;
   logic        err, miss = 1'b0;
   logic [15:0] perm_port_o, io_addr, p, deny = 16'h0000;
   logic [2:0]  perm_bytes_o;
   logic [3:0]  delay = 4'h0;
   pinx_pkg::pinx_io_req_t  io_cmd_o;
   pinx_pkg::pinx_mem_req_t mem_cmd_o, last;
   int          n_wr, w0, n_mismatch = 0, n_compared = 0, cyc = 0;
   logic [8:0]  pm[4] = '{9'h031, 9'h0f1, 9'h0c3, 9'h030};
   logic [2:0]  pf[4] = '{3'h1, 3'h0, 3'h1, 3'h0};
   logic [8:0]  sm[4] = '{9'h100, 9'h104, 9'h100, 9'h100};
   logic [31:0] sd[4] = '{32'h100, 32'habcd_0000, 32'h200, 32'h400};
   logic [31:0] sa[4] = '{32'h1100, 32'h1000, 32'h1208, 32'h1208};
   logic [31:0] se[4] = '{32'h101, 32'habcd_fffe, 32'h20c, 32'h400};
   logic [1:0]  sn[4] = '{2'h1, 2'h1, 2'h3, 2'h0};
   logic [8:0]  fm[5] = '{9'h001, 9'h100, 9'h139, 9'h108, 9'h100};
   logic [31:0] fd[5] = '{32'h200, 32'h1_0000, 32'h201, 32'h201, 32'h300};
   logic [2:0]  fe[5] = '{3'h1, 3'h1, 3'h3, 3'h0, 3'h2};
   pinx_core uut (.*);
   pinx_io_model model (.clock_i(clock_i), .resetn_i(resetn_i), .io_req_i(io_req_o), .io_cmd_i(io_cmd_o),
      .io_ack_o(io_ack_i), .io_rdata_o(io_rdata_i), .perm_port_i(perm_port_o), .perm_bytes_i(perm_bytes_o),
      .perm_deny_o(perm_deny_i), .mem_req_i(mem_req_o), .mem_cmd_i(mem_cmd_o), .mem_ack_o(mem_ack_i),
      .mem_page_miss_o(mem_page_miss_i), .delay_i(delay), .deny_port_i(deny), .miss_i(miss),
      .io_addr_o(io_addr), .mem_last_o(last), .n_wr_o(n_wr));
   always #25 clock_i = ~clock_i;
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e, input logic [31:0] k = 32'hffff_ffff);
      xfer(1'b0, a, 32'h0);
      chk(w, e & k, rd & k);
   endtask : rdc
   task automatic wt(input logic [2:0] f);
      int n;
      n = 0;
      do begin
         xfer(1'b0, pinx_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      chk("fault", {29'h0, f}, {29'h0, rd[3:1]});
   endtask : wt
   task automatic run(input logic [31:0] c, input logic [2:0] f);
      wr(pinx_pkg::OFS_CMD, c);
      wt(f);
   endtask : run
   function automatic logic [31:0] cmd(input logic [7:0] op, input logic [7:0] ib, input logic sz, input logic rp);
      return {8'h00, ib, op, 5'h00, rp, sz, 1'b1};
   endfunction : cmd
   // ------------------------------
   // Sequence
   // ------------------------------
   initial begin
      repeat (8) @(posedge clock_i);
      resetn_i <= 1'b1;
      rdc("mode", pinx_pkg::OFS_MODE, 32'h0);
      rdc("limit", pinx_pkg::OFS_ES_LIMIT, 32'h0000_ffff);
      rdc("mask", pinx_pkg::OFS_INT_MASK, 32'h0);
      rdc("unmapped", 8'h3c, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      wr(pinx_pkg::OFS_PORT_IDX, 32'h0000_beef);
      wr(pinx_pkg::OFS_COUNT, 32'h7);
      for (int i = 0; i < 6; i++) begin
         o = (i < 3 ? 8'he4 : 8'hec) | {7'h0, i % 3 != 0};
         im = (i == 2) ? 8'hff : 8'h5a;
         p = o[3] ? 16'hbeef : {8'h00, im};
         m = !o[0] ? 32'hff : (i % 3 == 2 ? 32'hffff_ffff : 32'hffff);
         delay <= 4'(i);
         run(cmd(o, im, i % 3 == 2, 1'b0), 3'h0);
         chk("port", {16'h0, p}, {16'h0, io_addr});
         rdc("acc", pinx_pkg::OFS_ACC, {~p, p}, m);
         rdc("count", pinx_pkg::OFS_COUNT, 32'h7);
      end
      deny <= 16'hbef0;
      for (int i = 0; i < 4; i++) begin
         wr(pinx_pkg::OFS_MODE, {23'h0, pm[i]});
         run(cmd(8'hed, 8'h00, 1'b0, 1'b0), pf[i]);
      end
      wr(pinx_pkg::OFS_ES_BASE, 32'h1000);
      for (int i = 0; i < 4; i++) begin
         wr(pinx_pkg::OFS_MODE, {23'h0, sm[i]});
         wr(pinx_pkg::OFS_DEST_IDX, sd[i]);
         wr(pinx_pkg::OFS_COUNT, {30'h0, sn[i]});
         w0 = n_wr;
         run(i < 2 ? cmd({7'h36, i[0]}, 8'h00, 1'b0, 1'b0) : cmd(8'h6d, 8'h00, 1'b1, 1'b1), 3'h0);
         chk("writes", {30'h0, sn[i]}, 32'(n_wr - w0));
         chk("mem addr", sa[i], last.addr);
         chk("mem data", 32'hef, {24'h0, last.wdata[7:0]});
         rdc("dest", pinx_pkg::OFS_DEST_IDX, se[i]);
         rdc("count", pinx_pkg::OFS_COUNT, i > 1 ? 32'h0 : 32'h1);
      end
      deny <= 16'h0000;
      for (int i = 0; i < 5; i++) begin
         wr(pinx_pkg::OFS_MODE, {23'h0, fm[i]});
         wr(pinx_pkg::OFS_DEST_IDX, fd[i]);
         miss <= (i == 4);
         run(cmd(8'h6d, 8'h00, 1'b1, 1'b0), fe[i]);
         rdc("dest", pinx_pkg::OFS_DEST_IDX, fe[i] == 3'h0 ? fd[i] + 32'h4 : fd[i]);
      end
      miss <= 1'b0;
      run(cmd(8'h90, 8'h00, 1'b0, 1'b0), 3'h5);
      delay <= 4'h8;
      wr(pinx_pkg::OFS_CMD, cmd(8'hec, 8'h00, 1'b0, 1'b0));
      wr(pinx_pkg::OFS_PORT_IDX, 32'h1111);
      wt(3'h0);
      rdc("port idx", pinx_pkg::OFS_PORT_IDX, 32'hbeef);
      wr(pinx_pkg::OFS_INT_STAT, 32'h3);
      wr(pinx_pkg::OFS_INT_MASK, 32'h1);
      #1 chk("irq", 32'h0, {31'h0, irq_o});
      run(cmd(8'hec, 8'h00, 1'b0, 1'b0), 3'h0);
      #1 chk("irq", 32'h1, {31'h0, irq_o});
      wr(pinx_pkg::OFS_INT_STAT, 32'h1);
      #1 chk("irq", 32'h0, {31'h0, irq_o});
      wr(pinx_pkg::OFS_INT_MASK, 32'h2);
      run(cmd(8'hec, 8'h00, 1'b0, 1'b0), 3'h0);
      #1 chk("irq", 32'h0, {31'h0, irq_o});
      rdc("int stat", pinx_pkg::OFS_INT_STAT, 32'h1, 32'h1);
      report_and_stop();
   end
endmodule : io_port_input_instructions_tb
bind pinx_core pinx_properties chk (.*);

// ### pinx_core.sv
module pinx_core (
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    resetn_i,
   // APB slave
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [7:0]              paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output logic [31:0]                  prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   // Interrupt
   output logic                         irq_o,
   // Permission bitmap, same cycle
   output logic [15:0]                  perm_port_o,
   output logic [2:0]                   perm_bytes_o,
   input  wire logic                    perm_deny_i,
   // I/O space read
   output logic                         io_req_o,
   output pinx_pkg::pinx_io_req_t       io_cmd_o,
   input  wire logic                    io_ack_i,
   input  wire logic [31:0]             io_rdata_i,
   // Memory write
   output logic                         mem_req_o,
   output pinx_pkg::pinx_mem_req_t      mem_cmd_o,
   input  wire logic                    mem_ack_i,
   input  wire logic                    mem_page_miss_i
);

   // --------------------
   // State
   // --------------------
   pinx_pkg::pinx_state_t state_q;
   pinx_pkg::pinx_state_t state_d;
   pinx_pkg::pinx_fault_t fault_q;
   pinx_pkg::pinx_fault_t fault_d;
   logic [7:0]            opc_q;
   logic [7:0]            imm_q;
   logic                  opsize32_q;
   logic                  rep_q;
   logic [8:0]            mode_q;
   logic [15:0]           port_idx_q;
   logic [31:0]           acc_q;
   logic [31:0]           dest_idx_q;
   logic [31:0]           count_q;
   logic [31:0]           es_base_q;
   logic [31:0]           es_limit_q;
   logic [1:0]            int_stat_q;
   logic [1:0]            int_mask_q;
   logic [31:0]           prdata_q;
   logic [31:0]           io_data_q;

   // --------------------
   // Bus decode
   // --------------------
   wire        bus_setup   = psel_i & ~penable_i;
   wire        bus_access  = psel_i & penable_i;
   wire        bus_wr      = bus_access & pwrite_i;
   wire        hit_cmd     = (paddr_i == pinx_pkg::OFS_CMD);
   wire        hit_mode    = (paddr_i == pinx_pkg::OFS_MODE);
   wire        hit_port    = (paddr_i == pinx_pkg::OFS_PORT_IDX);
   wire        hit_acc     = (paddr_i == pinx_pkg::OFS_ACC);
   wire        hit_dest    = (paddr_i == pinx_pkg::OFS_DEST_IDX);
   wire        hit_count   = (paddr_i == pinx_pkg::OFS_COUNT);
   wire        hit_base    = (paddr_i == pinx_pkg::OFS_ES_BASE);
   wire        hit_limit   = (paddr_i == pinx_pkg::OFS_ES_LIMIT);
   wire        hit_status  = (paddr_i == pinx_pkg::OFS_STATUS);
   wire        hit_istat   = (paddr_i == pinx_pkg::OFS_INT_STAT);
   wire        hit_imask   = (paddr_i == pinx_pkg::OFS_INT_MASK);
   wire        hit_any     = hit_cmd | hit_mode | hit_port | hit_acc | hit_dest | hit_count
                             | hit_base | hit_limit | hit_status | hit_istat | hit_imask;
   wire        idle        = (state_q == pinx_pkg::ST_IDLE);
   // Register writes ignored while busy, except interrupt status and mask
   wire        sw_wr       = bus_wr & idle;
   wire        start       = sw_wr & hit_cmd & pwdata_i[pinx_pkg::CMD_START];

   assign pready_o  = bus_access;
   assign pslverr_o = bus_access & ~hit_any;
   assign prdata_o  = prdata_q;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_cmd) begin
         rd_mux = {8'h00, imm_q, opc_q, 5'h00, rep_q, opsize32_q, 1'b0};
      end else if (hit_mode) begin
         rd_mux = {23'h000000, mode_q};
      end else if (hit_port) begin
         rd_mux = {16'h0000, port_idx_q};
      end else if (hit_acc) begin
         rd_mux = acc_q;
      end else if (hit_dest) begin
         rd_mux = dest_idx_q;
      end else if (hit_count) begin
         rd_mux = count_q;
      end else if (hit_base) begin
         rd_mux = es_base_q;
      end else if (hit_limit) begin
         rd_mux = es_limit_q;
      end else if (hit_status) begin
         rd_mux = {28'h0000000, fault_q, ~idle};
      end else if (hit_istat) begin
         rd_mux = {30'h00000000, int_stat_q};
      end else if (hit_imask) begin
         rd_mux = {30'h00000000, int_mask_q};
      end
   end

   // --------------------
   // Instruction decode
   // --------------------
   wire        pe       = mode_q[pinx_pkg::MODE_PE];
   wire        vm       = mode_q[pinx_pkg::MODE_VM];
   wire        df       = mode_q[pinx_pkg::MODE_DF];
   wire        ac_en    = mode_q[pinx_pkg::MODE_AC];
   wire        es_wr_ok = mode_q[pinx_pkg::MODE_ES_WR];
   wire [1:0]  current_privilege      = mode_q[pinx_pkg::MODE_CPL_LSB +: 2];
   wire [1:0]  io_privilege_level     = mode_q[pinx_pkg::MODE_IO_PRIVILEGE_LEVEL_LSB +: 2];

   wire        op_imm   = (opc_q == pinx_pkg::OPC_IN_IMM_B) | (opc_q == pinx_pkg::OPC_IN_IMM_V);
   wire        op_idx   = (opc_q == pinx_pkg::OPC_IN_IDX_B) | (opc_q == pinx_pkg::OPC_IN_IDX_V);
   wire        op_str   = (opc_q == pinx_pkg::OPC_INS_B) | (opc_q == pinx_pkg::OPC_INS_V);
   wire        op_valid = op_imm | op_idx | op_str;
   wire        op_byte  = (opc_q == pinx_pkg::OPC_IN_IMM_B) | (opc_q == pinx_pkg::OPC_IN_IDX_B)
                          | (opc_q == pinx_pkg::OPC_INS_B);

   // Byte opcodes fix the size
   wire [2:0]  xfer_bytes = op_byte ? 3'h1 : (opsize32_q ? 3'h4 : 3'h2);

   // Immediate ports stay below 256
   wire [15:0] port_addr  = op_imm ? {8'h00, imm_q} : port_idx_q;

   // --------------------
   // Fault checks
   // --------------------
   // Bitmap in virtual mode, or when privilege is not enough
   wire        need_perm  = pe & (vm | (current_privilege > io_privilege_level));
   wire        perm_fault = need_perm & perm_deny_i;

   // 16-bit size wraps in the low index
   wire [31:0] dest_ofs   = opsize32_q ? dest_idx_q : {16'h0000, dest_idx_q[15:0]};
   wire [32:0] dest_end   = {1'b0, dest_ofs} + {30'h00000000, xfer_bytes} - 33'h000000001;
   wire        lim_fault  = (dest_end > {1'b0, es_limit_q});
   wire        wr_fault   = pe & ~vm & ~es_wr_ok;
   wire        unaligned  = (xfer_bytes == 3'h2) ? dest_ofs[0]
                            : ((xfer_bytes == 3'h4) ? (dest_ofs[1:0] != 2'h0) : 1'b0);
   // Alignment checks only at user level or in virtual mode
   wire        ac_fault   = ac_en & pe & (vm | (current_privilege == pinx_pkg::PRIV_USER)) & unaligned;
   // Destination never on the stack, so no stack fault
   wire        seg_fault  = op_str & (lim_fault | wr_fault);

   // No segment override
   wire [31:0] mem_addr   = es_base_q + dest_ofs;

   // Step 1, 2 or 4
   wire [31:0] step       = {29'h00000000, xfer_bytes};
   wire [31:0] idx_next   = df ? (dest_idx_q - step) : (dest_idx_q + step);
   wire [31:0] idx_upd    = opsize32_q ? idx_next : {dest_idx_q[31:16], idx_next[15:0]};
   wire [31:0] count_dec  = count_q - 32'h0000_0001;
   wire        more       = rep_q & (count_dec != 32'h0000_0000);

   // Bits above the port width kept
   logic [31:0] acc_merge;
   always_comb begin
      acc_merge = acc_q;
      if (xfer_bytes == 3'h1) begin
         acc_merge[7:0] = io_rdata_i[7:0];
      end else if (xfer_bytes == 3'h2) begin
         acc_merge[15:0] = io_rdata_i[15:0];
      end else begin
         acc_merge = io_rdata_i;
      end
   end

   // --------------------
   // Sequencer
   // --------------------
   always_comb begin
      state_d = state_q;
      fault_d = fault_q;
      case (state_q)
         pinx_pkg::ST_IDLE: begin
            if (start) begin
               state_d = pinx_pkg::ST_CHECK;
               fault_d = pinx_pkg::FLT_NONE;
            end
         end
         pinx_pkg::ST_CHECK: begin
            if (!op_valid) begin
               state_d = pinx_pkg::ST_IDLE;
               fault_d = pinx_pkg::FLT_UD;
            end else if (op_str && rep_q && count_q == 32'h0000_0000) begin
               state_d = pinx_pkg::ST_IDLE;
            end else if (perm_fault) begin
               state_d = pinx_pkg::ST_IDLE;
               fault_d = pinx_pkg::FLT_GP;
            end else if (seg_fault) begin
               state_d = pinx_pkg::ST_IDLE;
               fault_d = pinx_pkg::FLT_GP;
            end else if (op_str && ac_fault) begin
               state_d = pinx_pkg::ST_IDLE;
               fault_d = pinx_pkg::FLT_AC;
            end else begin
               state_d = pinx_pkg::ST_IO;
            end
         end
         pinx_pkg::ST_IO: begin
            if (io_ack_i) begin
               state_d = op_str ? pinx_pkg::ST_MEM : pinx_pkg::ST_IDLE;
            end
         end
         pinx_pkg::ST_MEM: begin
            if (mem_ack_i) begin
               if (mem_page_miss_i) begin
                  state_d = pinx_pkg::ST_IDLE;
                  fault_d = pinx_pkg::FLT_PF;
               end else begin
                  state_d = pinx_pkg::ST_STEP;
               end
            end
         end
         pinx_pkg::ST_STEP: begin
            state_d = more ? pinx_pkg::ST_CHECK : pinx_pkg::ST_IDLE;
         end
         default: begin
            state_d = pinx_pkg::ST_IDLE;
         end
      endcase
   end

   wire finish    = ~idle & (state_d == pinx_pkg::ST_IDLE);
   wire fault_evt = finish & (fault_d != pinx_pkg::FLT_NONE);
   wire [1:0] evt = {fault_evt, finish & ~fault_evt};
   wire [1:0] clr = (bus_wr & hit_istat) ? pwdata_i[1:0] : 2'h0;

   // --------------------
   // Outward requests
   // --------------------
   assign perm_port_o     = port_addr;
   assign perm_bytes_o    = xfer_bytes;
   assign io_req_o        = (state_q == pinx_pkg::ST_IO);
   assign io_cmd_o.addr   = port_addr;
   assign io_cmd_o.bytes  = xfer_bytes;
   assign mem_req_o       = (state_q == pinx_pkg::ST_MEM);
   assign mem_cmd_o.addr  = mem_addr;
   assign mem_cmd_o.wdata = io_data_q;
   assign mem_cmd_o.bytes = xfer_bytes;
   assign irq_o           = |(int_stat_q & int_mask_q);

   // --------------------
   // Registers
   // --------------------
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= pinx_pkg::ST_IDLE;
         fault_q    <= pinx_pkg::FLT_NONE;
         prdata_q   <= 32'h0000_0000;
         int_stat_q <= 2'h0;
         int_mask_q <= pinx_pkg::INT_MASK_RST;
      end else begin
         state_q    <= state_d;
         fault_q    <= fault_d;
         if (bus_setup) begin
            prdata_q <= rd_mux;
         end
         // Set wins over a same-cycle clear
         int_stat_q <= (int_stat_q & ~clr) | evt;
         if (bus_wr && hit_imask) begin
            int_mask_q <= pwdata_i[1:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         opc_q      <= 8'h00;
         imm_q      <= 8'h00;
         opsize32_q <= 1'b0;
         rep_q      <= 1'b0;
         mode_q     <= pinx_pkg::MODE_RST;
         port_idx_q <= 16'h0000;
         es_base_q  <= 32'h0000_0000;
         es_limit_q <= pinx_pkg::ES_LIMIT_RST;
      end else if (sw_wr) begin
         if (hit_cmd) begin
            opc_q      <= pwdata_i[pinx_pkg::CMD_OPC_LSB +: 8];
            imm_q      <= pwdata_i[pinx_pkg::CMD_IMM_LSB +: 8];
            opsize32_q <= pwdata_i[pinx_pkg::CMD_OPSIZE32];
            rep_q      <= pwdata_i[pinx_pkg::CMD_REP];
         end
         if (hit_mode) begin
            mode_q <= pwdata_i[8:0];
         end
         if (hit_port) begin
            port_idx_q <= pwdata_i[15:0];
         end
         if (hit_base) begin
            es_base_q <= pwdata_i;
         end
         if (hit_limit) begin
            es_limit_q <= pwdata_i;
         end
      end
   end

   // No flags here
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc_q      <= 32'h0000_0000;
         dest_idx_q <= 32'h0000_0000;
         count_q    <= 32'h0000_0000;
         io_data_q  <= 32'h0000_0000;
      end else if (sw_wr) begin
         if (hit_acc) begin
            acc_q <= pwdata_i;
         end
         if (hit_dest) begin
            dest_idx_q <= pwdata_i;
         end
         if (hit_count) begin
            count_q <= pwdata_i;
         end
      end else if (state_q == pinx_pkg::ST_IO && io_ack_i) begin
         io_data_q <= io_rdata_i;
         if (!op_str) begin
            acc_q <= acc_merge;
         end
      end else if (state_q == pinx_pkg::ST_STEP) begin
         dest_idx_q <= idx_upd;
         if (rep_q) begin
            count_q <= count_dec;
         end
      end
   end

endmodule : pinx_core

// ### pinx_io_model.sv
module pinx_io_model (
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    resetn_i,
   // Device side
   input  wire logic                    io_req_i,
   input  wire pinx_pkg::pinx_io_req_t  io_cmd_i,
   output logic                         io_ack_o,
   output logic [31:0]                  io_rdata_o,
   input  wire logic [15:0]             perm_port_i,
   input  wire logic [2:0]              perm_bytes_i,
   output logic                         perm_deny_o,
   input  wire logic                    mem_req_i,
   input  wire pinx_pkg::pinx_mem_req_t mem_cmd_i,
   output logic                         mem_ack_o,
   output logic                         mem_page_miss_o,
   // Bench control
   input  wire logic [3:0]              delay_i,
   input  wire logic [15:0]             deny_port_i,
   input  wire logic                    miss_i,
   output logic [15:0]                  io_addr_o,
   output pinx_pkg::pinx_mem_req_t      mem_last_o,
   output int                           n_wr_o
);
   // ------------------------------
   // Peripheral and memory
   // ------------------------------
   logic [3:0]  cnt_q;
   logic [31:0] tick_q;
   wire  [16:0] lo_w = {1'b0, perm_port_i};
   wire  [16:0] dp_w = {1'b0, deny_port_i};
   // One denied port; any overlap of the accessed range denies
   assign perm_deny_o     = dp_w >= lo_w && dp_w < lo_w + {14'h0, perm_bytes_i};
   // Outside the ack cycle the data bus shows a moving pattern
   assign io_rdata_o      = io_ack_o ? {~io_cmd_i.addr, io_cmd_i.addr} : tick_q;
   assign mem_page_miss_o = mem_ack_o & miss_i;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         io_ack_o   <= 1'b0;
         mem_ack_o  <= 1'b0;
         cnt_q      <= 4'h0;
         tick_q     <= 32'h0000_0000;
         io_addr_o  <= 16'h0000;
         mem_last_o <= '0;
         n_wr_o     <= 0;
      end else begin
         tick_q    <= tick_q + 32'h9e37_79b9;
         io_ack_o  <= 1'b0;
         mem_ack_o <= 1'b0;
         if ((io_req_i && !io_ack_o) || (mem_req_i && !mem_ack_o)) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == delay_i) begin
               cnt_q     <= 4'h0;
               io_ack_o  <= io_req_i;
               mem_ack_o <= mem_req_i;
               if (io_req_i) begin
                  io_addr_o <= io_cmd_i.addr;
               end
               if (mem_req_i && !miss_i) begin
                  mem_last_o <= mem_cmd_i;
                  n_wr_o     <= n_wr_o + 1;
               end
            end
         end
      end
   end
endmodule : pinx_io_model

// ### pinx_pkg.sv
package pinx_pkg;

   // --------------------
   // Register byte offsets
   // --------------------
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_MODE     = 8'h04;
   localparam logic [7:0] OFS_PORT_IDX = 8'h08;
   localparam logic [7:0] OFS_ACC      = 8'h0c;
   localparam logic [7:0] OFS_DEST_IDX = 8'h10;
   localparam logic [7:0] OFS_COUNT    = 8'h14;
   localparam logic [7:0] OFS_ES_BASE  = 8'h18;
   localparam logic [7:0] OFS_ES_LIMIT = 8'h1c;
   localparam logic [7:0] OFS_STATUS   = 8'h20;
   localparam logic [7:0] OFS_INT_STAT = 8'h24;
   localparam logic [7:0] OFS_INT_MASK = 8'h28;

   // --------------------
   // Field positions
   // --------------------
   localparam int CMD_START    = 0;
   localparam int CMD_OPSIZE32 = 1;
   localparam int CMD_REP      = 2;
   localparam int CMD_OPC_LSB  = 8;
   localparam int CMD_IMM_LSB  = 16;
   localparam int MODE_PE      = 0;
   localparam int MODE_VM      = 1;
   localparam int MODE_DF      = 2;
   localparam int MODE_AC      = 3;
   localparam int MODE_CPL_LSB = 4;
   localparam int MODE_IO_PRIVILEGE_LEVEL_LSB = 6;
   localparam int MODE_ES_WR   = 8;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_FLT_LSB = 1;
   localparam int INT_DONE     = 0;
   localparam int INT_FAULT    = 1;

   // --------------------
   // Reset values and user privilege level
   // --------------------
   localparam logic [8:0]  MODE_RST     = 9'h000;
   localparam logic [31:0] ES_LIMIT_RST = 32'h0000_ffff;
   localparam logic [1:0]  INT_MASK_RST = 2'h0;
   localparam logic [1:0]  PRIV_USER    = 2'h3;

   // --------------------
   // Opcodes
   // --------------------
   localparam logic [7:0] OPC_IN_IMM_B = 8'he4;
   localparam logic [7:0] OPC_IN_IMM_V = 8'he5;
   localparam logic [7:0] OPC_IN_IDX_B = 8'hec;
   localparam logic [7:0] OPC_IN_IDX_V = 8'hed;
   localparam logic [7:0] OPC_INS_B    = 8'h6c;
   localparam logic [7:0] OPC_INS_V    = 8'h6d;

   typedef enum logic [2:0] {
      FLT_NONE  = 3'b000,
      FLT_GP    = 3'b001,
      FLT_PF    = 3'b010,
      FLT_AC    = 3'b011,
      FLT_SS    = 3'b100,
      FLT_UD    = 3'b101
   } pinx_fault_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_CHECK  = 3'b001,
      ST_IO     = 3'b010,
      ST_MEM    = 3'b011,
      ST_STEP   = 3'b100
   } pinx_state_t;

   // I/O space read request
   typedef struct packed {
      logic [15:0] addr;
      logic [2:0]  bytes;
   } pinx_io_req_t;

   // Memory write request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [2:0]  bytes;
   } pinx_mem_req_t;

endpackage : pinx_pkg

// ### pinx_properties.sv
module pinx_properties (
   // Clock and reset
   input wire logic                    clock_i,
   input wire logic                    resetn_i,
   // Register bus
   input wire logic                    psel_i,
   input wire logic                    penable_i,
   input wire logic                    pwrite_i,
   input wire logic [7:0]              paddr_i,
   input wire logic [31:0]             pwdata_i,
   input wire logic                    pready_o,
   // Transfers
   input wire logic                    perm_deny_i,
   input wire logic                    io_req_o,
   input wire pinx_pkg::pinx_io_req_t  io_cmd_o,
   input wire logic                    io_ack_i,
   input wire logic [31:0]             io_rdata_i,
   input wire logic                    mem_req_o,
   input wire pinx_pkg::pinx_mem_req_t mem_cmd_o,
   input wire logic                    mem_ack_i
);
   // ------------------------------
   // Tracking
   // ------------------------------
   logic [7:0]  opc_q;
   logic [7:0]  imm_q;
   logic        sz_q;
   logic [8:0]  mode_q;
   logic [15:0] pidx_q;
   logic [31:0] rd_q;
   wire         wr_w   = psel_i & penable_i & pwrite_i & !io_req_o & !mem_req_o;
   wire         go_w   = wr_w & (paddr_i == pinx_pkg::OFS_CMD) & pwdata_i[0];
   wire         imm_w  = opc_q[7:1] == 7'h72;
   wire         str_w  = opc_q[7:1] == 7'h36;
   wire         one_w  = opc_q[7:4] == 4'he;
   wire         need_w = mode_q[0] & (mode_q[1] | (mode_q[5:4] > mode_q[7:6]));
   wire [2:0]   nb_w   = !opc_q[0] ? 3'h1 : (sz_q ? 3'h4 : 3'h2);
   // Writes ignored only while a request is out
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         opc_q  <= 8'h00;
         imm_q  <= 8'h00;
         sz_q   <= 1'b0;
         mode_q <= 9'h000;
         pidx_q <= 16'h0000;
         rd_q   <= 32'h0000_0000;
      end else begin
         if (go_w) begin
            opc_q <= pwdata_i[15:8];
            imm_q <= pwdata_i[23:16];
            sz_q  <= pwdata_i[1];
         end
         if (wr_w && paddr_i == pinx_pkg::OFS_MODE) begin
            mode_q <= pwdata_i[8:0];
         end
         if (wr_w && paddr_i == pinx_pkg::OFS_PORT_IDX) begin
            pidx_q <= pwdata_i[15:0];
         end
         if (io_ack_i) begin
            rd_q <= io_rdata_i;
         end
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   sequence s_go_ok;
      go_w ##1 (one_w && !(perm_deny_i && need_w));
   endsequence
   sequence s_go_deny;
      go_w ##1 (one_w && perm_deny_i && need_w);
   endsequence
   a_pready_wait: assert property (psel_i && penable_i |-> pready_o)
      else $error("pready low in access phase");
   a_imm_port: assert property (io_req_o && imm_w |-> io_cmd_o.addr == {8'h00, imm_q})
      else $error("immediate port address wrong");
   a_idx_port: assert property (io_req_o && !imm_w |-> io_cmd_o.addr == pidx_q)
      else $error("index port address wrong");
   a_io_width: assert property (io_req_o |-> io_cmd_o.bytes == nb_w)
      else $error("port width wrong");
   a_io_hold: assert property (io_req_o && !io_ack_i |=> io_req_o && $stable(io_cmd_o))
      else $error("port request dropped");
   a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_cmd_o))
      else $error("memory request dropped");
   a_read_allowed: assert property (s_go_ok |=> io_req_o)
      else $error("allowed read not issued");
   a_deny_fault: assert property (s_go_deny |=> !io_req_o [*3])
      else $error("denied read issued");
   a_str_to_mem: assert property (io_ack_i && str_w |=> mem_req_o)
      else $error("string read not stored");
   a_mem_data: assert property (mem_req_o |-> mem_cmd_o.wdata[7:0] == rd_q[7:0] && mem_cmd_o.bytes == nb_w)
      else $error("memory data wrong");
   a_one_no_mem: assert property (mem_req_o |-> str_w)
      else $error("single form wrote memory");
endmodule : pinx_properties
